// ===== rtl/tces_timer.sv
// timer channel: two-capture and restart measurement, event counter, square wave
`timescale 1ns/100ps
`include "tces_params.svh"
module tces_timer (
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic [3:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    input  wire logic        i_trigger_input_a,
    output logic             o_wave_output_pin,
    output logic             o_match_irq_a,
    output logic             o_capture_irq_b
);

    // ----------------------------------------
    // functions
    // ----------------------------------------
    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        return a == off;
    endfunction

    function automatic tces_pkg::tces_mode_t decode_mode(input logic [1:0] m);
        case (m)
            `TCES_MODE_STOP:    return tces_pkg::TCES_ST_STOP;
            `TCES_MODE_RESTART: return tces_pkg::TCES_ST_RESTART;
            `TCES_MODE_FREE:    return tces_pkg::TCES_ST_FREE;
            default:            return tces_pkg::TCES_ST_MATCH;
        endcase
    endfunction

    function automatic logic edge_hit(input logic [1:0] es, input tces_pkg::tces_edge_t e);
        case (es)
            `TCES_ES_FALL: return e.fall;
            `TCES_ES_RISE: return e.rise;
            `TCES_ES_BOTH: return e.rise || e.fall;
            default:       return 1'b0;
        endcase
    endfunction

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic rst_meta_reg;
    logic rst_n_reg;

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    tces_pkg::tces_cfg_t  cfg_reg;
    tces_pkg::tces_mode_t mode_st;
    tces_pkg::tces_edge_t in_edge;
    logic                 ovf_reg;
    logic [15:0]          cca_reg;
    logic [15:0]          ccb_reg;
    logic [15:0]          count_reg;
    logic [7:0]           presc_reg;
    logic                 pin_reg;
    logic                 match_irq_reg;
    logic                 cap_irq_reg;
    logic [15:0]          rdata_reg;
    logic                 wr_mode;
    logic                 wr_cca;
    logic                 wr_ccb;
    logic                 event_mode;
    logic                 presc_tick;
    logic                 sample_en;
    logic                 valid_edge;
    logic                 opposite_edge;
    logic                 restart_edge;
    logic                 count_tick;
    logic                 match_evt;
    logic                 ovf_set;
    logic                 cap_a_evt;
    logic                 cap_b_evt;

    assign wr_mode = i_wr && hit(i_addr, `TCES_ADR_MODE);
    assign wr_cca  = i_wr && hit(i_addr, `TCES_ADR_CCA);
    assign wr_ccb  = i_wr && hit(i_addr, `TCES_ADR_CCB);
    assign mode_st = decode_mode(cfg_reg.mode);

    // ----------------------------------------
    // configuration writes
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            cfg_reg <= '0;
        else
        begin
            if (wr_mode)
                cfg_reg.mode <= i_wdata[3:2];
            if (i_wr && hit(i_addr, `TCES_ADR_CAPCTL))
            begin
                cfg_reg.a_capture <= i_wdata[0];
                cfg_reg.a_inverse <= i_wdata[1];
            end
            if (i_wr && hit(i_addr, `TCES_ADR_OUTCTL))
            begin
                cfg_reg.out_en    <= i_wdata[0];
                cfg_reg.toggle_en <= i_wdata[1];
            end
            if (i_wr && hit(i_addr, `TCES_ADR_CLKSEL))
            begin
                cfg_reg.clk_sel  <= i_wdata[1:0];
                cfg_reg.edge_sel <= i_wdata[5:4];
            end
        end
    end

    // ----------------------------------------
    // count clock and input filter
    // ----------------------------------------
    // the prescaler is held at zero while stopped so every start sees the same phase
    always_ff @(posedge i_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            presc_reg <= 8'h00;
        else if (mode_st == tces_pkg::TCES_ST_STOP)
            presc_reg <= 8'h00;
        else
            presc_reg <= presc_reg + `TCES_PRESC_ONE;
    end

    always_comb
    begin
        case (cfg_reg.clk_sel)
            `TCES_CLK_DIV4:   presc_tick = &presc_reg[1:0];
            `TCES_CLK_DIV16:  presc_tick = &presc_reg[3:0];
            `TCES_CLK_DIV256: presc_tick = &presc_reg;
            default:          presc_tick = 1'b0;
        endcase
    end

    assign event_mode = (mode_st == tces_pkg::TCES_ST_MATCH)
                        && (cfg_reg.clk_sel == `TCES_CLK_EVENT);

    assign sample_en = event_mode ? 1'b1 : presc_tick;

    tces_edge_filter u_filter (
        .i_clk    (i_clk),
        .i_rst_n  (rst_n_reg),
        .i_pin    (i_trigger_input_a),
        .i_sample (sample_en),
        .o_edge   (in_edge)
    );

    assign valid_edge = edge_hit(cfg_reg.edge_sel, in_edge);
    // rising or falling only; both reads as rising
    assign restart_edge = (cfg_reg.edge_sel == `TCES_ES_FALL) ? in_edge.fall : in_edge.rise;
    assign opposite_edge = (cfg_reg.edge_sel == `TCES_ES_RISE) ? in_edge.fall :
                           (cfg_reg.edge_sel == `TCES_ES_FALL) ? in_edge.rise : 1'b0;

    assign count_tick = event_mode ? valid_edge : presc_tick;

    // ----------------------------------------
    // counter
    // ----------------------------------------
    // match clears
    assign match_evt = (mode_st == tces_pkg::TCES_ST_MATCH) && count_tick
                       && (count_reg == cca_reg);
    assign ovf_set = count_tick && (count_reg == `TCES_CNT_MAX)
                     && ((mode_st != tces_pkg::TCES_ST_MATCH) || (cca_reg == `TCES_CNT_MAX))
                     && !((mode_st == tces_pkg::TCES_ST_RESTART) && restart_edge);
    assign cap_b_evt = ((mode_st == tces_pkg::TCES_ST_FREE) && valid_edge)
                       || ((mode_st == tces_pkg::TCES_ST_RESTART) && restart_edge);
    assign cap_a_evt = (mode_st == tces_pkg::TCES_ST_FREE) && cfg_reg.a_capture
                       && cfg_reg.a_inverse && opposite_edge;

    always_ff @(posedge i_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            count_reg <= `TCES_CNT_ZERO;
        else
        begin
            case (mode_st)
                tces_pkg::TCES_ST_STOP:
                    count_reg <= `TCES_CNT_ZERO;
                tces_pkg::TCES_ST_RESTART:
                    if (restart_edge)
                        count_reg <= `TCES_CNT_ZERO;
                    else if (count_tick)
                        count_reg <= count_reg + `TCES_CNT_ONE;
                tces_pkg::TCES_ST_FREE:
                    if (count_tick)
                        count_reg <= count_reg + `TCES_CNT_ONE;
                tces_pkg::TCES_ST_MATCH:
                    if (match_evt)
                        count_reg <= `TCES_CNT_ZERO;
                    else if (count_tick)
                        count_reg <= count_reg + `TCES_CNT_ONE;
                default:
                    count_reg <= `TCES_CNT_ZERO;
            endcase
        end
    end

    // ----------------------------------------
    // overflow flag and capture registers
    // ----------------------------------------
    // match mode wraps only when compare A is FFFFH; set beats a clearing write
    always_ff @(posedge i_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            ovf_reg <= 1'b0;
        else if (ovf_set)
            ovf_reg <= 1'b1;
        else if (wr_mode)
            ovf_reg <= i_wdata[0];
    end

    always_ff @(posedge i_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            cca_reg <= 16'h0000;
        else if (cap_a_evt)
            cca_reg <= count_reg;
        else if (wr_cca)
            cca_reg <= i_wdata;
    end

    always_ff @(posedge i_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            ccb_reg <= 16'h0000;
        else if (cap_b_evt)
            ccb_reg <= count_reg;
        else if (wr_ccb)
            ccb_reg <= i_wdata;
    end

    // ----------------------------------------
    // events and square wave
    // ----------------------------------------
    // restart captures flag B too
    always_ff @(posedge i_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            match_irq_reg <= 1'b0;
            cap_irq_reg   <= 1'b0;
        end
        else
        begin
            match_irq_reg <= match_evt;
            cap_irq_reg   <= cap_b_evt;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            pin_reg <= 1'b0;
        else if (!cfg_reg.out_en)
            pin_reg <= 1'b0;
        else if (match_evt && cfg_reg.toggle_en)
            pin_reg <= !pin_reg;
    end

    // ----------------------------------------
    // register read
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            rdata_reg <= 16'h0000;
        else if (!i_rd)
            rdata_reg <= 16'h0000;
        else
        begin
            case (i_addr)
                `TCES_ADR_MODE:   rdata_reg <= {12'h000, cfg_reg.mode, 1'b0, ovf_reg};
                `TCES_ADR_CAPCTL: rdata_reg <= {14'h0000, cfg_reg.a_inverse, cfg_reg.a_capture};
                `TCES_ADR_OUTCTL: rdata_reg <= {14'h0000, cfg_reg.toggle_en, cfg_reg.out_en};
                `TCES_ADR_CLKSEL: rdata_reg <= {10'h000, cfg_reg.edge_sel, 2'b00, cfg_reg.clk_sel};
                `TCES_ADR_CCA:    rdata_reg <= cca_reg;
                `TCES_ADR_CCB:    rdata_reg <= ccb_reg;
                `TCES_ADR_COUNT:  rdata_reg <= count_reg;
                default:          rdata_reg <= 16'h0000;
            endcase
        end
    end

    assign o_rdata           = rdata_reg;
    assign o_wave_output_pin = pin_reg;
    assign o_match_irq_a     = match_irq_reg;
    assign o_capture_irq_b   = cap_irq_reg;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n_reg);

    property p_stop_holds;
        (mode_st == tces_pkg::TCES_ST_STOP) |=> (count_reg == `TCES_CNT_ZERO);
    endproperty
    a_stop_holds: assert property (p_stop_holds) else $error("counter moved while stopped");

    property p_free_runs;
        (mode_st == tces_pkg::TCES_ST_FREE) && count_tick && !wr_mode
        |=> (count_reg == $past(count_reg) + `TCES_CNT_ONE);
    endproperty
    a_free_runs: assert property (p_free_runs) else $error("free counter did not advance");

    property p_cap_b;
        (mode_st == tces_pkg::TCES_ST_FREE) && valid_edge
        |=> (ccb_reg == $past(count_reg)) && o_capture_irq_b;
    endproperty
    a_cap_b: assert property (p_cap_b) else $error("capture B missed");

    property p_cap_a;
        cap_a_evt |=> (cca_reg == $past(count_reg)) && !o_match_irq_a;
    endproperty
    a_cap_a: assert property (p_cap_a) else $error("capture A missed");

    property p_restart;
        (mode_st == tces_pkg::TCES_ST_RESTART) && restart_edge && !wr_mode
        |=> (count_reg == `TCES_CNT_ZERO) && (ccb_reg == $past(count_reg)) && o_capture_irq_b;
    endproperty
    a_restart: assert property (p_restart) else $error("restart capture wrong");

    property p_event_count;
        event_mode && !valid_edge && !wr_mode |=> $stable(count_reg);
    endproperty
    a_event_count: assert property (p_event_count) else $error("count moved without edge");

    property p_match_clear;
        match_evt && !wr_mode |=> (count_reg == `TCES_CNT_ZERO) && o_match_irq_a;
    endproperty
    a_match_clear: assert property (p_match_clear) else $error("match did not clear");

    property p_ovf_cause;
        $rose(ovf_reg) && !$past(wr_mode)
        |-> ($past(count_reg) == `TCES_CNT_MAX) && (count_reg == `TCES_CNT_ZERO);
    endproperty
    a_ovf_cause: assert property (p_ovf_cause) else $error("overflow without wrap");

    property p_event_ovf;
        event_mode && $rose(ovf_reg) && !$past(wr_mode) |-> ($past(cca_reg) == `TCES_CNT_MAX);
    endproperty
    a_event_ovf: assert property (p_event_ovf) else $error("event overflow below FFFFH");

    property p_wave;
        match_evt && cfg_reg.out_en && cfg_reg.toggle_en
        ##1 cfg_reg.out_en |-> (o_wave_output_pin != $past(o_wave_output_pin));
    endproperty
    a_wave: assert property (p_wave) else $error("pin did not toggle");

endmodule

// ===== rtl/tces_params.svh
// constants for the capture / event / square-wave timer channel
// Summary of operation
// - two-capture mode: counter free-runs without clearing while input A widths are measured
// - two-capture mode: selected input A edge copies counter to capture B, flags B
// - two-capture mode: the opposite edge copies the counter into capture A
// - measurement inputs sampled on count clock; edge accepted after two equal samples
// - restart mode: valid edge captures counter into B, then counter restarts from zero
// - restart mode: edge select picks rising or falling edge as valid edge
// - event mode: counter advances once per valid input A edge, not count clock
// - event mode: counter equal to compare A clears to zero and flags match A
// - event mode: edge select picks rising, falling or both edges
// - event mode: input filter samples on main clock, two equal samples needed
// - event mode: overflow flag sets only when compare A holds FFFFH
// - square wave: enable and toggle bits set invert pin every compare A plus one ticks
// - overflow flag sets when the counter steps from FFFFH to 0000H
// - mode bits 00 hold the counter stopped; any other value starts it
`ifndef TCES_PARAMS_SVH
`define TCES_PARAMS_SVH

// ----------------------------------------
// register word addresses
// ----------------------------------------
`define TCES_ADR_MODE    4'h0
`define TCES_ADR_CAPCTL  4'h1
`define TCES_ADR_OUTCTL  4'h2
`define TCES_ADR_CLKSEL  4'h3
`define TCES_ADR_CCA     4'h4
`define TCES_ADR_CCB     4'h5
`define TCES_ADR_COUNT   4'h6

// ----------------------------------------
// field values
// ----------------------------------------
`define TCES_MODE_STOP    2'h0
`define TCES_MODE_RESTART 2'h1
`define TCES_MODE_FREE    2'h2
`define TCES_MODE_MATCH   2'h3
`define TCES_ES_FALL      2'h0
`define TCES_ES_RISE      2'h1
`define TCES_ES_BOTH      2'h3
`define TCES_CLK_DIV4     2'h0
`define TCES_CLK_DIV16    2'h1
`define TCES_CLK_DIV256   2'h2
`define TCES_CLK_EVENT    2'h3
`define TCES_CNT_MAX      16'hFFFF
`define TCES_CNT_ZERO     16'h0000
`define TCES_CNT_ONE      16'h0001
`define TCES_PRESC_ONE    8'h01

`endif

// ===== rtl/tces_pkg.sv
// types shared by the timer channel modules
package tces_pkg;

    typedef enum logic [3:0] {
        TCES_ST_STOP    = 4'b0001,
        TCES_ST_RESTART = 4'b0010,
        TCES_ST_FREE    = 4'b0100,
        TCES_ST_MATCH   = 4'b1000
    } tces_mode_t;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] clk_sel;
        logic [1:0] edge_sel;
        logic       a_capture;
        logic       a_inverse;
        logic       out_en;
        logic       toggle_en;
    } tces_cfg_t;

    typedef struct packed {
        logic rise;
        logic fall;
    } tces_edge_t;

endpackage

// ===== rtl/tces_edge_filter.sv
// synchroniser and two-sample noise filter for input A
`timescale 1ns/100ps
module tces_edge_filter (
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_pin,
    input  wire logic              i_sample,
    output tces_pkg::tces_edge_t   o_edge
);
    logic sync1_reg;
    logic sync2_reg;
    logic samp_reg;
    logic level_reg;
    logic rise_reg;
    logic fall_reg;
    logic accept;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= i_pin;
            sync2_reg <= sync1_reg;
        end
    end

    assign accept = i_sample && (sync2_reg == samp_reg) && (samp_reg != level_reg);

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            samp_reg  <= 1'b0;
            level_reg <= 1'b0;
        end
        else if (i_sample)
        begin
            samp_reg <= sync2_reg;
            if (accept)
                level_reg <= samp_reg;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
        end
        else
        begin
            rise_reg <= accept && samp_reg;
            fall_reg <= accept && !samp_reg;
        end
    end

    assign o_edge.rise = rise_reg;
    assign o_edge.fall = fall_reg;

endmodule

// ===== testbench/tces_pulse_src.sv
// partner model: external pulse source that drives trigger input A
`timescale 1ns/100ps
module tces_pulse_src (
    input  wire logic i_clk,
    output logic      o_pin
);
    // ----------------------------------------
    // pin driver
    // ----------------------------------------
    // the line idles low, as a pull-down would leave it between pulses
    initial o_pin = 1'b0;

    // one pulse: high for n_high clocks, then low for n_low clocks;
    // the pin only moves just after a rising edge of the bench clock
    task automatic pulse(input int n_high, input int n_low);
        repeat (n_high) @(posedge i_clk) o_pin <= 1'b1;
        repeat (n_low) @(posedge i_clk) o_pin <= 1'b0;
    endtask
endmodule

// ===== testbench/tces_timer_tb.sv
// self-checking testbench for the capture / event / square-wave timer channel
`timescale 1ns/100ps
`include "tces_params.svh"
module tces_timer_tb;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam int SQ_N = 4;
    localparam int PER  = 64;
    logic        i_clk;
    logic        i_resetn;
    logic [3:0]  i_addr;
    logic [15:0] i_wdata;
    logic        i_wr;
    logic        i_rd;
    logic [15:0] o_rdata;
    logic        trig_a;
    logic        o_wave_output_pin;
    logic        o_match_irq_a;
    logic        o_capture_irq_b;
    logic [15:0] v_a;
    logic [15:0] v_b;
    int          n_mismatch;
    int          compares;
    int          cyc;
    int          n_irq_a;
    int          n_irq_b;
    int          t0;
    int          t1;
    int          t2;
    int          ia;
    int          ib;

    tces_timer u_tces_timer (
        .i_clk             (i_clk),
        .i_resetn          (i_resetn),
        .i_addr            (i_addr),
        .i_wdata           (i_wdata),
        .i_wr              (i_wr),
        .i_rd              (i_rd),
        .o_rdata           (o_rdata),
        .i_trigger_input_a (trig_a),
        .o_wave_output_pin (o_wave_output_pin),
        .o_match_irq_a     (o_match_irq_a),
        .o_capture_irq_b   (o_capture_irq_b)
    );

    tces_pulse_src u_tces_pulse_src (
        .i_clk (i_clk),
        .o_pin (trig_a)
    );

    // ----------------------------------------
    // clock, interrupt tallies, hang guard
    // ----------------------------------------
    always #20 i_clk = ~i_clk;

    always @(posedge i_clk)
    begin
        cyc = cyc + 1;
        if (o_match_irq_a === 1'b1) n_irq_a = n_irq_a + 1;
        if (o_capture_irq_b === 1'b1) n_irq_b = n_irq_b + 1;
        if (cyc == 20000)
        begin
            n_mismatch = n_mismatch + 1;
            give_verdict();
        end
    end

    // ----------------------------------------
    // bus tasks and checks
    // ----------------------------------------
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares = compares + 1;
        if (got !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd(a, d);
        chk(d, exp);
    endtask

    // waits for the square-wave pin to change, bounded
    task automatic wait_pin(output int t);
        logic was;
        int   k;
        was = o_wave_output_pin;
        for (k = 0; k < 200 && o_wave_output_pin === was; k++)
        begin
            @(posedge i_clk);
            #1;
        end
        t = cyc;
    endtask

    task automatic give_verdict();
        if (n_mismatch == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        i_clk = 1'b0;
        i_resetn = 1'b0;
        i_addr = 4'h0;
        i_wdata = 16'h0000;
        i_wr = 1'b0;
        i_rd = 1'b0;
        n_mismatch = 0;
        compares = 0;
        cyc = 0;
        n_irq_a = 0;
        n_irq_b = 0;
        repeat (3) @(posedge i_clk);
        i_resetn <= 1'b1;
        repeat (3) @(posedge i_clk);
        // stopped counter, read-only count, unmapped place, overflow bit
        rchk(4'hF, 16'h0000);
        wr(`TCES_ADR_COUNT, 16'h1234);
        repeat (8) @(posedge i_clk);
        rchk(`TCES_ADR_COUNT, 16'h0000);
        wr(`TCES_ADR_MODE, 16'h0001);
        rchk(`TCES_ADR_MODE, 16'h0001);
        wr(`TCES_ADR_MODE, 16'h0000);
        rchk(`TCES_ADR_MODE, 16'h0000);
        // event counter, rising edges, compare A of 3
        wr(`TCES_ADR_CAPCTL, 16'h0000);
        wr(`TCES_ADR_CLKSEL, 16'h0013);
        wr(`TCES_ADR_CCA, 16'h0003);
        rchk(`TCES_ADR_CCA, 16'h0003);
        wr(`TCES_ADR_MODE, 16'h000C);
        ia = n_irq_a;
        repeat (2) u_tces_pulse_src.pulse(8, 8);
        rchk(`TCES_ADR_COUNT, 16'h0002);
        u_tces_pulse_src.pulse(1, 8);
        rchk(`TCES_ADR_COUNT, 16'h0002);
        repeat (2) u_tces_pulse_src.pulse(8, 8);
        rchk(`TCES_ADR_COUNT, 16'h0000);
        chk(16'(n_irq_a - ia), 16'h0001);
        chk({15'h0000, o_wave_output_pin}, 16'h0000);
        // both edges, then falling only
        wr(`TCES_ADR_MODE, 16'h0000);
        wr(`TCES_ADR_CLKSEL, 16'h0033);
        wr(`TCES_ADR_MODE, 16'h000C);
        u_tces_pulse_src.pulse(8, 8);
        rchk(`TCES_ADR_COUNT, 16'h0002);
        wr(`TCES_ADR_MODE, 16'h0000);
        wr(`TCES_ADR_CLKSEL, 16'h0003);
        wr(`TCES_ADR_MODE, 16'h000C);
        u_tces_pulse_src.pulse(8, 8);
        rchk(`TCES_ADR_COUNT, 16'h0001);
        // edge select of none counts nothing
        wr(`TCES_ADR_MODE, 16'h0000);
        wr(`TCES_ADR_CLKSEL, 16'h0023);
        wr(`TCES_ADR_MODE, 16'h000C);
        u_tces_pulse_src.pulse(8, 8);
        rchk(`TCES_ADR_COUNT, 16'h0000);
        // two captures on a free-running count clock of main/4
        wr(`TCES_ADR_MODE, 16'h0000);
        wr(`TCES_ADR_CAPCTL, 16'h0003);
        wr(`TCES_ADR_CLKSEL, 16'h0010);
        wr(`TCES_ADR_MODE, 16'h0008);
        ib = n_irq_b;
        u_tces_pulse_src.pulse(24, 40);
        rd(`TCES_ADR_CCB, v_b);
        rd(`TCES_ADR_CCA, v_a);
        chk(v_a - v_b, 16'(24 / 4));
        chk(16'(n_irq_b - ib), 16'h0001);
        u_tces_pulse_src.pulse(3, 20);
        chk(16'(n_irq_b - ib), 16'h0001);
        rd(`TCES_ADR_COUNT, v_a);
        repeat (38) @(posedge i_clk);
        rd(`TCES_ADR_COUNT, v_b);
        chk(v_b - v_a, 16'(40 / 4));
        // restart measurement on falling edges
        wr(`TCES_ADR_MODE, 16'h0000);
        wr(`TCES_ADR_CAPCTL, 16'h0000);
        wr(`TCES_ADR_CLKSEL, 16'h0000);
        wr(`TCES_ADR_MODE, 16'h0004);
        ib = n_irq_b;
        repeat (3) u_tces_pulse_src.pulse(24, PER - 24);
        rchk(`TCES_ADR_CCB, 16'(PER / 4));
        chk(16'(n_irq_b - ib), 16'h0003);
        // square wave, compare A of SQ_N, mode register written last
        wr(`TCES_ADR_MODE, 16'h0000);
        wr(`TCES_ADR_CLKSEL, 16'h0001);
        wr(`TCES_ADR_CAPCTL, 16'h0000);
        wr(`TCES_ADR_OUTCTL, 16'h0003);
        wr(`TCES_ADR_CCA, 16'(SQ_N));
        wr(`TCES_ADR_MODE, 16'h000C);
        // compare A stays untouched while the wave runs
        wait_pin(t0);
        ia = n_irq_a;
        wait_pin(t1);
        wait_pin(t2);
        chk(16'(t1 - t0), 16'((SQ_N + 1) * 16));
        chk(16'(t2 - t1), 16'((SQ_N + 1) * 16));
        chk(16'(n_irq_a - ia), 16'h0002);
        wr(`TCES_ADR_OUTCTL, 16'h0000);
        repeat (2) @(posedge i_clk);
        chk({15'h0000, o_wave_output_pin}, 16'h0000);
        // free run on main/256: two ticks in 512 clocks
        wr(`TCES_ADR_MODE, 16'h0000);
        wr(`TCES_ADR_CLKSEL, 16'h0002);
        wr(`TCES_ADR_MODE, 16'h0008);
        rd(`TCES_ADR_COUNT, v_a);
        repeat (510) @(posedge i_clk);
        rd(`TCES_ADR_COUNT, v_b);
        chk(v_b - v_a, 16'h0002);
        give_verdict();
    end
endmodule
